// ===== core/link_settings_defs.vh
// constants for the link settings command block
`ifndef LINK_SETTINGS_DEFS_VH
`define LINK_SETTINGS_DEFS_VH

// register byte offsets
`define OFS_CMD        5'h00
`define OFS_STATUS     5'h04
`define OFS_SETTINGS   5'h08
`define OFS_ROUTE_WR   5'h0c
`define OFS_ROUTE_RD   5'h10

// command register fields
`define CMD_OP_LSB     0
`define CMD_OP_MSB     3
`define CMD_VAL_LSB    8
`define CMD_VAL_MSB    15

// command opcodes
`define OP_PARITY      4'h1
`define OP_STOP        4'h2
`define OP_ROUTE_ATT   4'h3
`define OP_ROUTE_REUSE 4'h4
`define OP_LEVEL_ATT   4'h5
`define OP_ROUTE_SET   4'h6

// value codes
`define PARITY_NONE    2'h0
`define PARITY_EVEN    2'h1
`define PARITY_ODD     2'h2
`define STOP_ONE       8'h01
`define STOP_TWO       8'h02
`define FLAG_OF        8'h00
`define FLAG_ON        8'h01

// route layout
`define ROUTE_MAX      11
`define ROUTE_MAX_ID   8'hfe
`define ROUTE_BCAST_ID 8'h00
`define ROUTE_UNASSIGNED 4'h0

// reset values
`define RST_PARITY     2'h0
`define RST_TWO_STOP   1'b0
`define RST_FLAG       1'b0

`endif

// ===== core/link_settings.v
// settings part of the modem command interpreter, avalon-mm register front end
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "link_settings_defs.vh"

module link_settings (
    // clock and reset
    input  wire        mclk,
    input  wire        arst_n,
    // avalon-mm slave
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // operation mode pin, high in command mode
    input  wire        command_mode_code,
    // response formatter handshake
    output reg         resp_start,
    output reg         resp_ok,
    output reg  [3:0]  resp_op,
    output reg  [7:0]  resp_value,
    input  wire        resp_done,
    // uart framing in effect
    output reg  [1:0]  uart_parity,
    output reg         uart_two_stop,
    // receive side events
    input  wire        rx_id_we,
    input  wire [3:0]  rx_id_idx,
    input  wire [7:0]  rx_id,
    input  wire        rx_pkt_done,
    input  wire [3:0]  rx_route_len,
    input  wire        rx_from_src_tx,
    input  wire [7:0]  rx_level_dbm,
    input  wire        tx_variant3,
    // receive output formatting
    output reg         route_attach_flag,
    output reg         rx_hdr_with_level,
    output reg  [7:0]  rx_level_code,
    // transmit routing
    input  wire [3:0]  route_rd_idx,
    output reg  [7:0]  route_rd_id,
    output reg  [3:0]  route_len,
    output reg         route_use_dest_id,
    output reg         route_direct,
    output reg         route_broadcast,
    output reg         reply_to_source
);

    reg        mode_meta_q;
    reg        mode_sync_q;
    reg        ack_q;
    reg [1:0]  parity_q;
    reg        two_stop_q;
    reg [1:0]  parity_pend_q;
    reg        two_stop_pend_q;
    reg        pend_q;
    reg        route_reuse_flag_q;
    reg        level_att_q;
    reg        captured_q;
    reg [3:0]  route_len_q;
    reg [3:0]  rd_sel_q;
    reg [1:0]  last_res_q;
    reg [7:0]  relay_route_register [0:`ROUTE_MAX-1];
    reg [7:0]  stage_q [0:`ROUTE_MAX-1];
    reg [7:0]  rx_route_q [0:`ROUTE_MAX-1];
    wire [`ROUTE_MAX-1:0] stage_bad;

    wire       wr_hit = write & ~ack_q;
    wire       rd_hit = read & ~ack_q;
    wire [3:0] op     = writedata[`CMD_OP_MSB:`CMD_OP_LSB];
    wire [7:0] val    = writedata[`CMD_VAL_MSB:`CMD_VAL_LSB];
    wire       cmd_wr = wr_hit & (address == `OFS_CMD) & byteenable[0] & byteenable[1];
    wire       is_flag = (val == `FLAG_OF) | (val == `FLAG_ON);
    wire       capture = route_reuse_flag_q & rx_pkt_done & rx_from_src_tx;

    // one wait cycle per access keeps readdata a clean flop
    assign waitrequest = (read | write) & ~ack_q;

    // value check per staged id
    genvar gi;
    generate
        for (gi = 0; gi < `ROUTE_MAX; gi = gi + 1) begin : g_route
            assign stage_bad[gi] = (gi < route_cnt(val)) && (stage_q[gi] > `ROUTE_MAX_ID);
        end
    endgenerate

    function [3:0] route_cnt;
        input [7:0] v;
        begin
            route_cnt = v[3:0];
        end
    endfunction

    reg        ok_d;
    always @* begin
        ok_d = 1'b0;
        case (op)
            `OP_PARITY:      ok_d = (val[7:2] == 6'h00) & (val[1:0] != 2'h3);
            `OP_STOP:        ok_d = (val == `STOP_ONE) | (val == `STOP_TWO);
            `OP_ROUTE_ATT:   ok_d = is_flag;
            `OP_ROUTE_REUSE: ok_d = is_flag;
            `OP_LEVEL_ATT:   ok_d = is_flag;
            `OP_ROUTE_SET:   ok_d = (val <= `ROUTE_MAX) & ~|stage_bad;
            default:         ok_d = 1'b0;
        endcase
        ok_d = ok_d & mode_sync_q;
    end

    // mode pin synchroniser
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end else begin
            mode_meta_q <= command_mode_code;
            mode_sync_q <= mode_meta_q;
        end
    end

    // bus acknowledge and read data
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q    <= 1'b0;
            readdata <= 32'h00000000;
        end else begin
            ack_q <= (read | write) & ~ack_q;
            if (rd_hit) begin
                if (address == `OFS_STATUS) begin
                    readdata <= {12'h000, resp_op, resp_value, 4'h0, mode_sync_q, pend_q, last_res_q};
                end else if (address == `OFS_SETTINGS) begin
                    readdata <= {16'h0000, captured_q, 3'h0, route_len_q, 2'h0, level_att_q,
                                 route_reuse_flag_q, route_attach_flag, two_stop_q, parity_q};
                end else if (address == `OFS_ROUTE_RD) begin
                    readdata <= {24'h000000, relay_route_register[rd_sel_q]};
                end else begin
                    readdata <= 32'h00000000;
                end
            end
        end
    end

    // settings, response, framing hand-over
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            parity_q           <= `RST_PARITY;
            two_stop_q         <= `RST_TWO_STOP;
            parity_pend_q      <= `RST_PARITY;
            two_stop_pend_q    <= `RST_TWO_STOP;
            pend_q             <= 1'b0;
            uart_parity        <= `RST_PARITY;
            uart_two_stop      <= `RST_TWO_STOP;
            route_attach_flag  <= `RST_FLAG;
            route_reuse_flag_q <= `RST_FLAG;
            level_att_q        <= `RST_FLAG;
            resp_start         <= 1'b0;
            resp_ok            <= 1'b0;
            resp_op            <= 4'h0;
            resp_value         <= 8'h00;
            last_res_q         <= 2'h0;
            rd_sel_q           <= 4'h0;
        end else begin
            resp_start <= 1'b0;
            if (cmd_wr) begin
                resp_start <= 1'b1;
                resp_ok    <= ok_d;
                resp_op    <= op;
                resp_value <= val;
                last_res_q <= ok_d ? 2'h1 : 2'h2;
                if (ok_d) begin
                    case (op)
                        `OP_PARITY: begin
                            parity_pend_q <= val[1:0];
                            pend_q        <= 1'b1;
                        end
                        `OP_STOP: begin
                            two_stop_pend_q <= (val == `STOP_TWO);
                            pend_q          <= 1'b1;
                        end
                        `OP_ROUTE_ATT:   route_attach_flag  <= val[0];
                        `OP_ROUTE_REUSE: route_reuse_flag_q <= val[0];
                        `OP_LEVEL_ATT:   level_att_q        <= val[0];
                        default: ;
                    endcase
                end
            end else if (pend_q & resp_done) begin
                // framing only moves once the echo left in the old framing
                uart_parity   <= parity_pend_q;
                uart_two_stop <= two_stop_pend_q;
                parity_q      <= parity_pend_q;
                two_stop_q    <= two_stop_pend_q;
                pend_q        <= 1'b0;
            end
            if (wr_hit & (address == `OFS_ROUTE_RD) & byteenable[0]) begin
                rd_sel_q <= (writedata[3:0] < `ROUTE_MAX) ? writedata[3:0] : 4'h0;
            end
        end
    end

    // route storage: host staging, receive shadow, live register
    integer i;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < `ROUTE_MAX; i = i + 1) begin
                relay_route_register[i] <= 8'h00;
                stage_q[i]              <= 8'h00;
                rx_route_q[i]           <= 8'h00;
            end
            route_len_q <= `ROUTE_UNASSIGNED;
            captured_q  <= 1'b0;
        end else begin
            if (wr_hit & (address == `OFS_ROUTE_WR) & byteenable[0] & byteenable[1]
                & (writedata[3:0] < `ROUTE_MAX)) begin
                stage_q[writedata[3:0]] <= writedata[15:8];
            end
            if (rx_id_we & (rx_id_idx < `ROUTE_MAX)) begin
                rx_route_q[rx_id_idx] <= rx_id;
            end
            // a received route wins over a host write in the same cycle
            if (capture) begin
                for (i = 0; i < `ROUTE_MAX; i = i + 1) begin
                    relay_route_register[i] <= rx_route_q[i];
                end
                route_len_q <= (rx_route_len > `ROUTE_MAX) ? 4'hb : rx_route_len;
                captured_q  <= 1'b1;
            end else if (cmd_wr & ok_d & (op == `OP_ROUTE_SET)) begin
                for (i = 0; i < `ROUTE_MAX; i = i + 1) begin
                    relay_route_register[i] <= stage_q[i];
                end
                route_len_q <= val[3:0];
                captured_q  <= 1'b0;
            end
            // a capture in the same cycle keeps its marker
            if (cmd_wr & ok_d & (op == `OP_ROUTE_REUSE) & ~val[0] & ~capture) begin
                captured_q <= 1'b0;
            end
        end
    end

    // outputs toward formatter and transmitter
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_hdr_with_level <= 1'b0;
            rx_level_code     <= 8'h00;
            route_rd_id       <= 8'h00;
            route_len         <= `ROUTE_UNASSIGNED;
            route_use_dest_id <= 1'b1;
            route_direct      <= 1'b0;
            route_broadcast   <= 1'b0;
            reply_to_source   <= 1'b0;
        end else begin
            rx_hdr_with_level <= level_att_q | tx_variant3;
            rx_level_code     <= 8'h00 - rx_level_dbm;
            route_rd_id       <= (route_rd_idx < `ROUTE_MAX) ? relay_route_register[route_rd_idx] : 8'h00;
            route_len         <= route_len_q;
            route_use_dest_id <= (route_len_q == `ROUTE_UNASSIGNED);
            route_direct      <= (route_len_q == 4'h1);
            route_broadcast   <= (route_len_q != `ROUTE_UNASSIGNED)
                                 & (relay_route_register[route_len_q - 4'h1] == `ROUTE_BCAST_ID);
            reply_to_source   <= route_reuse_flag_q & captured_q;
        end
    end

endmodule // link_settings

// ===== bench/link_settings_properties.sv
// assertion checker for the link settings block
`timescale 1ns/1ps
module link_settings_properties (
    // clock, reset, bus
    input wire logic       mclk, arst_n, read, write, waitrequest,
    // response handshake and framing
    input wire logic       resp_start, resp_done, uart_two_stop,
    input wire logic [1:0] uart_parity,
    // level and routing
    input wire logic       tx_variant3, rx_hdr_with_level, route_use_dest_id, route_direct,
    input wire logic [7:0] rx_level_dbm, rx_level_code,
    input wire logic [3:0] route_len
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_ACK_SECOND: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
    AST_START_PULSE: assert property (resp_start |=> !resp_start) else $error("start not a pulse");
    AST_PARITY_LATE: assert property ($changed(uart_parity) |-> $past(resp_done)) else $error("parity early");
    AST_STOP_LATE: assert property ($changed(uart_two_stop) |-> $past(resp_done)) else $error("stop early");
    AST_PARITY_CODE: assert property (uart_parity != 2'h3) else $error("bad parity code");
    AST_LEVEL_CODE: assert property ($past(arst_n) |-> rx_level_code == 8'h00 - $past(rx_level_dbm))
        else $error("level code wrong");
    AST_VARIANT3: assert property ($past(arst_n) && $past(tx_variant3) |-> rx_hdr_with_level)
        else $error("variant 3 lacks level");
    AST_UNASSIGNED: assert property (route_len == 4'h0 |-> route_use_dest_id) else $error("dest id unused");
    AST_DIRECT: assert property (route_direct == (route_len == 4'h1)) else $error("direct wrong");
    AST_ROUTE_MAX: assert property (route_len <= 4'hb) else $error("route too long");

    cover property (resp_done ##1 $changed(uart_parity));
    cover property (route_direct);
    cover property (tx_variant3 ##1 rx_hdr_with_level);
endmodule // link_settings_properties

bind link_settings link_settings_properties props (.*);

// ===== bench/resp_model.sv
// response formatter and host uart stand-in
`timescale 1ns/1ps
module resp_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // response request from the block
    input  wire logic       resp_start,
    input  wire logic       resp_ok,
    input  wire logic [3:0] resp_op,
    input  wire logic [7:0] resp_value,
    input  wire logic       slow,
    // answer and host framing
    output logic            resp_done,
    output logic [1:0]      host_parity,
    output logic            host_two_stop
);
    logic [4:0] cnt_q;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 5'h00;
            resp_done <= 1'b0;
            host_parity <= 2'h0;
            host_two_stop <= 1'b0;
        end else begin
            resp_done <= (cnt_q == 5'h01);
            // slow mode keeps the old framing visible for a while
            if (resp_start)
                cnt_q <= slow ? 5'h14 : 5'h02;
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
            // host follows the new framing as soon as the text is out
            if (cnt_q == 5'h01 && resp_ok && resp_op == 4'h1)
                host_parity <= resp_value[1:0];
            if (cnt_q == 5'h01 && resp_ok && resp_op == 4'h2)
                host_two_stop <= (resp_value == 8'h02);
        end
    end
endmodule // resp_model

// ===== bench/tb_top.sv
// self-checking bench for the link settings block
`timescale 1ns/1ps
module tb_top;
    logic        mclk, arst_n, read, write, command_mode_code, slow, resp_done, rx_id_we, rx_pkt_done;
    logic        rx_from_src_tx, tx_variant3, waitrequest, resp_start, resp_ok, uart_two_stop, host_two_stop;
    logic        route_attach_flag, rx_hdr_with_level, route_use_dest_id, route_direct, route_broadcast;
    logic        reply_to_source;
    logic [1:0]  uart_parity, host_parity;
    logic [3:0]  byteenable, rx_id_idx, rx_route_len, route_rd_idx, resp_op, route_len;
    logic [4:0]  address;
    logic [7:0]  rx_id, rx_level_dbm, rx_level_code, route_rd_id, resp_value;
    logic [31:0] writedata, readdata, rd;
    int          n_errors = 0;
    int          checks = 0;
    int          cyc = 0;

    link_settings dut (.*);
    resp_model far (.*);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results;
        end
    end

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask

    // hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rchk(input string w, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(w, e, rd & m);
    endtask

    task automatic cmd(input logic [3:0] op, input logic [7:0] v);
        bus(1'b1, 5'h00, {16'h0, v, 4'h0, op});
    endtask

    task automatic done;
        for (int i = 0; i < 40 && resp_done !== 1'b1; i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
    endtask

    task automatic rxpkt(input logic [3:0] n, input logic s);
        for (int i = 0; i < n; i++) begin
            rx_id_we <= 1'b1;
            rx_id_idx <= 4'(i);
            rx_id <= 8'h20 + 8'(i);
            @(posedge mclk);
        end
        rx_id_we <= 1'b0;
        rx_pkt_done <= 1'b1;
        rx_route_len <= n;
        rx_from_src_tx <= s;
        @(posedge mclk);
        rx_pkt_done <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    logic [7:0] pv[4] = '{8'h01, 8'h02, 8'h00, 8'h03};
    logic [1:0] pe[4] = '{2'h1, 2'h2, 2'h0, 2'h0};
    logic [7:0] route[4] = '{8'h01, 8'h02, 8'h03, 8'h8f};
    logic [1:0] cur;

    initial begin
        {arst_n, read, write, slow, rx_id_we, rx_pkt_done, rx_from_src_tx, tx_variant3} = '0;
        {address, writedata, rx_id_idx, rx_route_len, route_rd_idx, rx_id, rx_level_dbm} = '0;
        byteenable = 4'hf;
        command_mode_code = 1'b1;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk("settings", 5'h08, 32'h8f3f, 32'h0);
        chk("dest id", 32'h1, route_use_dest_id);
        slow <= 1'b1;
        cur = 2'h0;
        for (int i = 0; i < 4; i++) begin
            cmd(4'h1, pv[i]);
            chk("parity before answer", cur, uart_parity);
            done;
            cur = pe[i];
            chk("parity", cur, uart_parity);
            chk("host parity", cur, host_parity);
            rchk("status", 5'h04, 32'hff03, {16'h0, pv[i], (i == 3) ? 8'h02 : 8'h01});
        end
        slow <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            cmd(4'h2, (i == 2) ? 8'h03 : (8'h02 - 8'(i)));
            done;
            chk("two stop", (i == 0), uart_two_stop);
            chk("host stop", (i == 0), host_two_stop);
        end
        for (int op = 3; op < 6; op++) begin
            cmd(4'(op), 8'h01);
            done;
            cmd(4'(op), 8'h02);
            done;
            rchk("flag", 5'h08, 32'h1 << op, 32'h1 << op);
        end
        chk("attach port", 32'h1, route_attach_flag);
        chk("level header", 32'h1, rx_hdr_with_level);
        for (int i = 0; i < 4; i++) bus(1'b1, 5'h0c, {16'h0, route[i], 4'h0, 4'(i)});
        cmd(4'h6, 8'h04);
        done;
        route_rd_idx <= 4'h3;
        repeat (2) @(posedge mclk);
        chk("route last", 32'h8f, route_rd_id);
        cmd(4'h6, 8'h0c);
        done;
        rchk("route len", 5'h08, 32'hf00, 32'h400);
        bus(1'b1, 5'h0c, 32'h0000ff00);
        cmd(4'h6, 8'h01);
        done;
        chk("id above fe", 32'h4, route_len);
        bus(1'b1, 5'h0c, 32'h0);
        cmd(4'h6, 8'h01);
        done;
        chk("direct", 32'h3, {route_direct, route_broadcast});
        cmd(4'h6, 8'h00);
        done;
        chk("unassigned", 32'h1, {route_len, route_use_dest_id});
        rxpkt(4'h2, 1'b0);
        chk("not from source", 32'h0, route_len);
        rxpkt(4'h2, 1'b1);
        route_rd_idx <= 4'h1;
        repeat (2) @(posedge mclk);
        chk("captured", 32'h221, {route_len, route_rd_id});
        chk("reply", 32'h1, reply_to_source);
        cmd(4'h4, 8'h00);
        done;
        rxpkt(4'h3, 1'b1);
        chk("reuse off", 32'h2, route_len);
        rx_level_dbm <= 8'hab;
        cmd(4'h5, 8'h00);
        done;
        chk("level code", 32'h55, rx_level_code);
        chk("plain header", 32'h0, rx_hdr_with_level);
        tx_variant3 <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("variant 3", 32'h1, rx_hdr_with_level);
        command_mode_code <= 1'b0;
        repeat (3) @(posedge mclk);
        cmd(4'h1, 8'h01);
        done;
        rchk("not command mode", 5'h04, 32'h3, 32'h2);
        chk("parity kept", 32'h0, uart_parity);
        results;
    end
endmodule // tb_top
